// ===== verification/lcd_column_timing_control_test.sv
`timescale 1ns/10ps
`include "lct_regs.vh"
module lcd_column_timing_control_test;
  reg         pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg         hsel_n = 1'b1, hrd_n = 1'b1, hwr_n = 1'b1, ms = 1'b1, dbn = 1'b1, trn = 1'b1;
  reg         bad = 1'b0, e, ok, sd = 1'b0, fd = 1'b1, pfd = 1'b1;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, q, xa, xb;
  reg  [15:0] ga = 16'h0, gb = 16'h0;
  integer     miscompares = 0, check_count = 0, nfr = 0, nst = 0, fcyc = 0, i, n, k;
  wire [31:0] prdata;
  wire        pready, pslverr, ready_out, ready_oe, rf_out, rf_oe, fpi, lsi, lai, lbi;
  wire        frame_pulse_n, line_strobe, level_select_a, level_select_b, timing_oe;
  wire        column_blank, row_blank_out_n;
  wire        rdy = ready_oe ? ready_out : 1'b1;
  wire        rfn = trn & (rf_oe ? rf_out : 1'b1);
  always #25 pclk = ~pclk;
  always @(posedge pclk) begin
    sd  <= line_strobe;
    fd  <= frame_pulse_n;
    pfd <= fpi;
    fcyc <= (!pfd && fpi) ? 0 : fcyc + 1;
    if (fd && !frame_pulse_n)
      nfr <= nfr + 1;
    if (!sd && line_strobe) begin
      ga  <= {ga[14:0], level_select_a};
      gb  <= {gb[14:0], level_select_b};
      nst <= nst + 1;
    end
  end
  // host strobes and blank shared in parallel; no test pin is driven
  lct_top #(.OSC_CYCLES(2)) DUT (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .host_select_n(hsel_n), .host_read_n(hrd_n),
    .host_write_n(hwr_n), .ready_out(ready_out), .ready_oe(ready_oe), .master_select(ms),
    .display_blank_n(dbn), .timing_refresh_n_in(rfn), .timing_refresh_n_out(rf_out),
    .timing_refresh_n_oe(rf_oe), .frame_pulse_n_in(fpi), .line_strobe_in(lsi),
    .level_select_a_in(lai), .level_select_b_in(lbi), .frame_pulse_n(frame_pulse_n),
    .line_strobe(line_strobe), .level_select_a(level_select_a),
    .level_select_b(level_select_b), .timing_oe(timing_oe), .column_blank(column_blank),
    .row_blank_out_n(row_blank_out_n));
  lct_partner #(.OSC(2)) far (.pclk(pclk), .presetn(presetn), .init(~rfn), .corrupt(bad),
    .frame_pulse_n(fpi), .line_strobe(lsi), .level_select_a(lai), .level_select_b(lbi));
  // ==========================================
  // tasks
  task end_sim;
    begin
      $display("checks %0d miscompares %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask
  task to;
    begin
      miscompares = miscompares + 1;
      $display("ERROR t=%0t wait limit reached", $time);
      end_sim;
    end
  endtask
  task chk(input [31:0] g, input [31:0] x);
    begin
      check_count = check_count + 1;
      if (g !== x) begin
        miscompares = miscompares + 1;
        $display("ERROR t=%0t got %h exp %h", $time, g, x);
      end
    end
  endtask
  task cyc(input integer c);
    begin
      repeat (c) @(posedge pclk);
      @(negedge pclk);
    end
  endtask
  task apb(input w, input [11:0] a, input [31:0] d);
    integer j;
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      for (j = 0; pready !== 1'b1; j = j + 1) begin
        if (j > 20)
          to;
        @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    cyc(1);
    chk(column_blank, 1);
    apb(0, `LCT_ADDR_CTRL, 0);
    chk(q, `LCT_CTRL_RESET);
    apb(0, `LCT_ADDR_STATUS, 0);
    chk(q & 3, 1);
    apb(0, 12'h008, 0);
    chk(e, 1);
    chk(q, 0);
    apb(1, `LCT_ADDR_CTRL, 3);
    apb(0, `LCT_ADDR_CTRL, 0);
    chk(q, 3);
    apb(1, `LCT_ADDR_CTRL, `LCT_CTRL_RESET);
    $display("test registers done");
    for (i = 0; column_blank !== 1'b0; i = i + 1) begin
      if (i > 40000)
        to;
      @(negedge pclk);
    end
    chk(nfr >= 7 && nfr <= 9, 1);
    apb(0, `LCT_ADDR_STATUS, 0);
    chk(q & 3, 3);
    n = nst;
    for (i = 0; nst < n + 17; i = i + 1) begin
      if (i > 2000)
        to;
      @(negedge pclk);
    end
    ok = 0;
    for (k = 0; k < 16; k = k + 1) begin
      xa = {ga, ga} >> k;
      xb = {gb, gb} >> k;
      if (xa[15:0] == 16'hff00 && xb[15:0] == 16'ha55a)
        ok = 1;
    end
    chk(ok, 1);
    $display("test master timing done");
    @(posedge pclk);
    dbn <= 1'b0;
    cyc(2);
    chk({column_blank, row_blank_out_n}, 2'b10);
    @(posedge pclk);
    dbn <= 1'b1;
    cyc(2);
    chk({column_blank, row_blank_out_n}, 2'b01);
    $display("test blank input done");
    for (k = 0; k < 2; k = k + 1) begin
      // start the access just after a strobe step, inside the panel fetch
      for (i = 0; !(line_strobe === 1'b1 && sd === 1'b0); i = i + 1) begin
        if (i > 100)
          to;
        @(negedge pclk);
      end
      @(posedge pclk);
      hsel_n <= 1'b0;
      hrd_n  <= k[0];
      hwr_n  <= ~k[0];
      cyc(1);
      chk({ready_oe, rdy}, 2'b10);
      for (i = 0; rdy !== 1'b1; i = i + 1) begin
        if (i > 20)
          to;
        @(negedge pclk);
      end
      @(posedge pclk);
      {hsel_n, hrd_n, hwr_n} <= 3'b111;
      cyc(1);
      chk({ready_oe, rdy}, 2'b01);
    end
    $display("test host wait done");
    @(posedge pclk);
    presetn <= 1'b0;
    ms      <= 1'b0;
    bad     <= 1'b1;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (i = 0; rf_oe !== 1'b1; i = i + 1) begin
      if (i > 8000)
        to;
      @(negedge pclk);
    end
    chk({rf_oe, rf_out}, 2'b10);
    chk(fcyc < 6, 1);
    chk(timing_oe, 0);
    cyc(2);
    chk(column_blank, 1);
    apb(0, `LCT_ADDR_STATUS, 0);
    chk(q & 5, 4);
    apb(1, `LCT_ADDR_STATUS, 4);
    apb(0, `LCT_ADDR_STATUS, 0);
    chk(q & 4, 0);
    $display("test slave check done");
    end_sim;
  end
endmodule

// ===== verification/lct_partner.sv
`timescale 1ns/10ps
module lct_partner #(
  parameter OSC = 2
) (
  input  wire pclk,
  input  wire presetn,
  input  wire init,
  input  wire corrupt,
  output wire frame_pulse_n,
  output wire line_strobe,
  output wire level_select_a,
  output wire level_select_b
);
  // ==========================================
  // master timing source seen by a slave
  reg [7:0] tick;
  reg [3:0] ph;
  reg [6:0] line;
  reg [3:0] idx;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn || init) begin
      tick <= 8'h00;
      ph   <= 4'h0;
      line <= 7'h00;
      idx  <= 4'h0;
    end else if (tick == OSC - 1) begin
      tick <= 8'h00;
      ph   <= ph + 4'h1;
      if (ph == 4'h7) begin
        line <= (line == 7'd80) ? 7'h00 : line + 7'h01;
        idx  <= idx + 4'h1;
      end
    end else begin
      tick <= tick + 8'h01;
    end
  end
  assign line_strobe    = ph[3];
  assign frame_pulse_n  = line != 7'd80;
  // corrupt flips one level select to provoke the slave check
  assign level_select_a = ~idx[3] ^ corrupt;
  assign level_select_b = ~(idx[0] ^ idx[2] ^ idx[3]);
endmodule

// ===== verification/lct_top_asserts.sv
`timescale 1ns/10ps
module lct_checker #(
  parameter OSC_CYCLES = 110
) (
  input wire pclk,
  input wire presetn,
  input wire host_select_n,
  input wire host_read_n,
  input wire host_write_n,
  input wire ready_out,
  input wire ready_oe,
  input wire master_select,
  input wire display_blank_n,
  input wire timing_refresh_n_in,
  input wire timing_refresh_n_oe,
  input wire frame_pulse_n,
  input wire line_strobe,
  input wire timing_oe,
  input wire column_blank,
  input wire row_blank_out_n
);
  // ==========================================
  // run lengths and strobes per half frame
  reg        ls_d, fp_d, fseen;
  reg [11:0] run;
  reg [7:0]  nst;
  reg [1:0]  seen;
  wire       chg     = line_strobe != ls_d;
  wire       ris     = line_strobe & ~ls_d;
  wire       ffall   = fp_d & ~frame_pulse_n;
  wire       host_go = ~host_select_n & ~(host_read_n & host_write_n);
  // first runs after init are partial, so they are skipped
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ls_d  <= 1'b0;
      fp_d  <= 1'b1;
      fseen <= 1'b0;
      run   <= 12'h000;
      nst   <= 8'h00;
      seen  <= 2'h0;
    end else begin
      ls_d <= line_strobe;
      fp_d <= frame_pulse_n;
      run  <= chg ? 12'h001 : run + 12'h001;
      nst  <= ffall ? {7'h00, ris} : nst + {7'h00, ris};
      if (!timing_refresh_n_in)
        seen <= 2'h0;
      else if (chg && seen != 2'h3)
        seen <= seen + 2'h1;
      if (!timing_refresh_n_in)
        fseen <= 1'b0;
      else if (ffall)
        fseen <= 1'b1;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  reset_blank_a: assert property ($rose(presetn) |-> column_blank && !row_blank_out_n)
    else $error("display not blank after reset");
  blank_in_a: assert property (!display_blank_n ##1 !display_blank_n |->
    column_blank && !row_blank_out_n) else $error("blank input ignored");
  refresh_blank_a: assert property (!timing_refresh_n_in ##1 !timing_refresh_n_in |->
    column_blank && !row_blank_out_n) else $error("refresh low not blank");
  ready_hiz_a: assert property (host_select_n |-> !ready_oe)
    else $error("ready driven while not selected");
  ready_drv_a: assert property (host_go |-> ready_oe)
    else $error("ready not driven during access");
  // each strobe step hands the ram to the panel fetch for four cycles
  wait_start_a: assert property (master_select && $rose(line_strobe) |->
    (!ready_out)[*4] ##1 ready_out) else $error("no wait during panel fetch");
  wait_end_a: assert property (!ready_out |-> ##[1:4] ready_out)
    else $error("wait never ends");
  strobe_half_a: assert property (master_select && chg && seen >= 2'h2 |->
    run == 8 * OSC_CYCLES) else $error("strobe phase length wrong");
  half_lines_a: assert property (master_select && ffall && fseen |-> nst == 8'd81)
    else $error("strobes per half frame wrong");
  refresh_len_a: assert property ($rose(timing_refresh_n_oe) |->
    timing_refresh_n_oe[*8] ##1 timing_refresh_n_oe[*8] ##1 !timing_refresh_n_oe)
    else $error("refresh pulse length wrong");
  timing_dir_a: assert property (timing_oe == master_select)
    else $error("timing pins driven in wrong mode");
  c_refresh: cover property ($rose(timing_refresh_n_oe));
  c_half: cover property (ffall && fseen);
  c_wait: cover property ($rose(host_go));
endmodule

bind lct_top lct_checker #(.OSC_CYCLES(OSC_CYCLES)) chk (.pclk(pclk), .presetn(presetn),
  .host_select_n(host_select_n), .host_read_n(host_read_n), .host_write_n(host_write_n),
  .ready_out(ready_out), .ready_oe(ready_oe), .master_select(master_select),
  .display_blank_n(display_blank_n), .timing_refresh_n_in(timing_refresh_n_in),
  .timing_refresh_n_oe(timing_refresh_n_oe), .frame_pulse_n(frame_pulse_n),
  .line_strobe(line_strobe), .timing_oe(timing_oe), .column_blank(column_blank),
  .row_blank_out_n(row_blank_out_n));

// ===== verilog/lct_blank_hold.v
`timescale 1ns/10ps
`include "lct_regs.vh"

module lct_blank_hold #(
  parameter FRAMES = `LCT_BLANK_FRAMES
) (
  input  wire pclk,
  input  wire presetn,
  input  wire ce,
  input  wire hold,
  input  wire frame_start,
  output wire blank
);

  reg [2:0] remain;

  // ==================================================
  // count full frames once the hold is released
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      remain <= FRAMES[2:0];
    end else if (ce) begin
      if (hold) begin
        remain <= FRAMES[2:0];
      end else if (frame_start && remain != 3'h0) begin
        remain <= remain - 3'h1;
      end
    end
  end

  assign blank = (remain != 3'h0) || hold;

endmodule

// ===== verilog/lct_line_gen.v
`timescale 1ns/10ps
`include "lct_regs.vh"

module lct_line_gen #(
  parameter PHASES = `LCT_STB_OSC_CYCLES,
  parameter LINES  = `LCT_LINES_PER_HALF
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       ce,
  input  wire       init,
  input  wire       osc_tick,
  input  wire       ext_step,
  input  wire       master,
  output reg        line_strobe,
  output reg        frame_pulse_n,
  output reg        level_select_a,
  output reg        level_select_b,
  output reg  [6:0] line_index,
  output reg        half_index,
  output wire       frame_start,
  output wire       fetch_start
);

  reg  [3:0] phase;
  reg  [3:0] seq;
  wire       step;
  wire [3:0] next_seq;
  wire [3:0] next_phase;

  localparam [3:0] LAST_PHASE = PHASES[3:0] - 4'h1;
  localparam [3:0] HALF_PHASE = PHASES[4:1];

  // ==================================================
  // strobe pacing: oscillator in master, incoming strobe in slave
  assign step        = master ? (osc_tick && phase == LAST_PHASE) : ext_step;
  assign next_phase  = (phase == LAST_PHASE) ? 4'h0 : phase + 4'h1;
  assign frame_start = step && half_index && line_index == LINES[6:0] - 7'h1;
  assign fetch_start = step;
  assign next_seq    = seq + 4'h1;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // parked on the last phase so the first tick is a full strobe step
      phase          <= LAST_PHASE;
      seq            <= 4'h0;
      line_index     <= 7'h00;
      half_index     <= 1'b0;
      line_strobe    <= 1'b0;
      frame_pulse_n  <= 1'b1;
      level_select_a <= 1'b1;
      level_select_b <= 1'b1;
    end else if (ce) begin
      if (init) begin
        phase          <= LAST_PHASE;
        seq            <= 4'h0;
        line_index     <= 7'h00;
        half_index     <= 1'b0;
        line_strobe    <= 1'b0;
        frame_pulse_n  <= 1'b1;
        level_select_a <= 1'b1;
        level_select_b <= 1'b1;
      end else begin
        if (master && osc_tick) begin
          phase       <= next_phase;
          line_strobe <= next_phase < HALF_PHASE;
        end
        if (step) begin
          seq <= next_seq;
          // groups of four strobes select the level pattern
          level_select_a <= ~next_seq[3];
          level_select_b <= next_seq[0] ^ ~(next_seq[3] ^ next_seq[2]);
          if (line_index == LINES[6:0] - 7'h1) begin
            line_index    <= 7'h00;
            half_index    <= ~half_index;
            frame_pulse_n <= 1'b0;
          end else begin
            line_index    <= line_index + 7'h01;
            frame_pulse_n <= 1'b1;
          end
        end
      end
    end
  end

endmodule

// ===== verilog/lct_regs.vh
// Notes on behaviour
// - wait the host when its access collides with the panel-side display RAM read.
// - ready pin is three-state so several devices share one pulled-up line.
// - reset stops oscillator, clears timing and diagnostics, blanks display.
// - after reset release the display stays off for 4 frames.
// - refresh low stops oscillator, clears timing generators, blanks display.
// - after refresh release the display stays off for 4 frames.
// - display-blank low drives every column output to the V1 level.
// - display-blank low also drives the row-blank output low.
// - master generates frame pulse, line strobe and both level selects.
// - frame pulse twice a frame, 81 strobes per half frame.
// - level select a: 1,1,0,0 per group; b: 1010,0101,0101,1010.
// - slave compares master level selects with its own; mismatch drives refresh.
// - refresh reinitialises timing; blank for 4 frames plus refresh low time.
// - mismatch check once per half frame at frame pulse rising edge.
// - only the master runs the oscillator and drives timing pins.
// - master line strobe period is 16 oscillator cycles, 8 high, 8 low.
`ifndef LCT_REGS_VH
`define LCT_REGS_VH

// ==================================================
// register map
`define LCT_ADDR_CTRL        12'h000
`define LCT_ADDR_STATUS      12'h004
`define LCT_CTRL_FORCE_BLANK 0
`define LCT_CTRL_DIAG_EN     1
`define LCT_CTRL_RESET       32'h0000_0002
`define LCT_STAT_MASTER      0
`define LCT_STAT_DISPLAY_ON  1
`define LCT_STAT_MISMATCH    2
`define LCT_STAT_HALF        3
`define LCT_STAT_LINE_LSB    8

// ==================================================
// timing
`define LCT_CLK_PERIOD_NS    50
`define LCT_OSC_PERIOD_NS    5511
`define LCT_OSC_CYCLES       (`LCT_OSC_PERIOD_NS / `LCT_CLK_PERIOD_NS)
`define LCT_STB_OSC_CYCLES   16
`define LCT_LINES_PER_HALF   81
`define LCT_BLANK_FRAMES     4
`define LCT_REFRESH_CYCLES   16
`define LCT_FETCH_CYCLES     4

`endif

// ===== verilog/lct_top.v
`timescale 1ns/10ps
`include "lct_regs.vh"

module lct_top #(
  parameter OSC_CYCLES    = `LCT_OSC_CYCLES,
  parameter REFRESH_CYCLES = `LCT_REFRESH_CYCLES,
  parameter FETCH_CYCLES  = `LCT_FETCH_CYCLES
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        ce,
  // apb
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // host parallel bus strobes
  input  wire        host_select_n,
  input  wire        host_read_n,
  input  wire        host_write_n,
  output wire        ready_out,
  output wire        ready_oe,
  // control pins
  input  wire        master_select,
  input  wire        display_blank_n,
  input  wire        timing_refresh_n_in,
  output wire        timing_refresh_n_out,
  output wire        timing_refresh_n_oe,
  // timing pins, driven in master mode, read in slave mode
  input  wire        frame_pulse_n_in,
  input  wire        line_strobe_in,
  input  wire        level_select_a_in,
  input  wire        level_select_b_in,
  output wire        frame_pulse_n,
  output wire        line_strobe,
  output wire        level_select_a,
  output wire        level_select_b,
  output wire        timing_oe,
  // display
  output reg         column_blank,
  output reg         row_blank_out_n
);

  reg  [31:0] ctrl;
  reg         mismatch_seen;
  reg  [7:0]  osc_div;
  reg         osc_tick;
  reg         strobe_prev;
  reg         frame_prev_n;
  reg         check_dly;
  reg  [4:0]  refresh_cnt;
  reg  [2:0]  fetch_cnt;
  wire        init;
  wire        slave_step;
  wire        check_edge;
  wire        mismatch;
  wire        frame_start;
  wire        fetch_start;
  wire        hold_blank;
  wire        host_access;
  wire        display_on;
  wire        wr_en;
  wire        rd_en;
  wire        addr_ok;
  wire [6:0]  line_index;
  wire        half_index;
  wire        gen_strobe;
  wire        gen_frame_n;
  wire        gen_lvl_a;
  wire        gen_lvl_b;

  // ==================================================
  // apb slave, zero wait states
  assign pready  = 1'b1;
  assign addr_ok = paddr == `LCT_ADDR_CTRL || paddr == `LCT_ADDR_STATUS;
  assign pslverr = psel && penable && !addr_ok;
  assign wr_en   = psel && penable && pwrite;
  assign rd_en   = psel && !penable && !pwrite;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl   <= `LCT_CTRL_RESET;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      if (wr_en && paddr == `LCT_ADDR_CTRL) begin
        ctrl <= {30'h0000_0000, pwdata[1:0]};
      end
      if (rd_en) begin
        case (paddr)
          `LCT_ADDR_CTRL: begin
            prdata <= ctrl;
          end
          `LCT_ADDR_STATUS: begin
            prdata <= {17'h00000, line_index, 4'h0, half_index, mismatch_seen,
                       display_on, master_select};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  // ==================================================
  // oscillator model: stopped while reset or refresh is low
  assign init = !timing_refresh_n_in;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_div  <= 8'h00;
      osc_tick <= 1'b0;
    end else if (ce) begin
      // slaves leave their oscillator idle
      if (init || !master_select) begin
        osc_div  <= 8'h00;
        osc_tick <= 1'b0;
      end else if (osc_div == OSC_CYCLES[7:0] - 8'h01) begin
        osc_div  <= 8'h00;
        osc_tick <= 1'b1;
      end else begin
        osc_div  <= osc_div + 8'h01;
        osc_tick <= 1'b0;
      end
    end
  end

  // ==================================================
  // slave follows strobe edges from the master
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strobe_prev  <= 1'b0;
      frame_prev_n <= 1'b1;
      check_dly    <= 1'b0;
    end else if (ce) begin
      strobe_prev  <= line_strobe_in;
      frame_prev_n <= frame_pulse_n_in;
      // compare a cycle late, once our own step for that strobe has landed
      check_dly    <= check_edge;
    end
  end

  assign slave_step = line_strobe_in && !strobe_prev;
  assign check_edge = frame_pulse_n_in && !frame_prev_n;

  lct_line_gen #(
    .PHASES (`LCT_STB_OSC_CYCLES),
    .LINES  (`LCT_LINES_PER_HALF)
  ) u_gen (
    .pclk           (pclk),
    .presetn        (presetn),
    .ce             (ce),
    .init           (init),
    .osc_tick       (osc_tick),
    .ext_step       (slave_step),
    .master         (master_select),
    .line_strobe    (gen_strobe),
    .frame_pulse_n  (gen_frame_n),
    .level_select_a (gen_lvl_a),
    .level_select_b (gen_lvl_b),
    .line_index     (line_index),
    .half_index     (half_index),
    .frame_start    (frame_start),
    .fetch_start    (fetch_start)
  );

  assign timing_oe      = master_select;
  assign line_strobe    = gen_strobe;
  assign frame_pulse_n  = gen_frame_n;
  assign level_select_a = gen_lvl_a;
  assign level_select_b = gen_lvl_b;

  // ==================================================
  // self-diagnostic: slave only, checked on frame pulse rise
  assign mismatch = !master_select && ctrl[`LCT_CTRL_DIAG_EN] && check_dly &&
                    !init && (level_select_a_in != gen_lvl_a ||
                    level_select_b_in != gen_lvl_b);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      refresh_cnt   <= 5'h00;
      mismatch_seen <= 1'b0;
    end else if (ce) begin
      if (mismatch) begin
        refresh_cnt <= REFRESH_CYCLES[4:0];
      end else if (refresh_cnt != 5'h00) begin
        refresh_cnt <= refresh_cnt - 5'h01;
      end
      // set wins over a write-one clear in the same cycle
      if (mismatch) begin
        mismatch_seen <= 1'b1;
      end else if (wr_en && paddr == `LCT_ADDR_STATUS && pwdata[`LCT_STAT_MISMATCH]) begin
        mismatch_seen <= 1'b0;
      end
    end
  end

  // open drain: only ever pulls low
  assign timing_refresh_n_out = 1'b0;
  assign timing_refresh_n_oe  = refresh_cnt != 5'h00;

  // ==================================================
  // display blanking
  lct_blank_hold #(
    .FRAMES (`LCT_BLANK_FRAMES)
  ) u_hold (
    .pclk        (pclk),
    .presetn     (presetn),
    .ce          (ce),
    .hold        (init),
    .frame_start (frame_start),
    .blank       (hold_blank)
  );

  assign display_on = display_blank_n && !hold_blank && !ctrl[`LCT_CTRL_FORCE_BLANK];

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      column_blank    <= 1'b1;
      row_blank_out_n <= 1'b0;
    end else if (ce) begin
      column_blank    <= !display_on;
      row_blank_out_n <= display_on;
    end
  end

  // ==================================================
  // host wait: panel fetch owns the single-port ram briefly after each strobe
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fetch_cnt <= 3'h0;
    end else if (ce) begin
      if (fetch_start) begin
        fetch_cnt <= FETCH_CYCLES[2:0];
      end else if (fetch_cnt != 3'h0) begin
        fetch_cnt <= fetch_cnt - 3'h1;
      end
    end
  end

  assign host_access = !host_select_n && (!host_read_n || !host_write_n);
  // released while not selected so other devices can share the line
  assign ready_oe    = host_access;
  assign ready_out   = fetch_cnt == 3'h0;

endmodule
